// >>> rtl/irq_cfg_defs.vh
/*
 register offsets, field positions, reset values for the interrupt
 controller configuration block. assumes byte addressing on a 32-bit
 apb with one aligned word per register.
*/
`ifndef IRQ_CFG_DEFS_VH
`define IRQ_CFG_DEFS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_IRQ_CONTROL 8'h00
`define OFS_SHADOW_SELECT 8'h10
`define OFS_SERVICE_STATUS 8'h20
`define OFS_PROX_RELOAD 8'h30

// ----------------------------------------------------------------
// irq_control fields
// ----------------------------------------------------------------
`define POS_EDGE_POL_LO 0
`define POS_EDGE_POL_HI 4
`define POS_TRIGGER_LO 8
`define POS_TRIGGER_HI 10
`define POS_MULTIVECTOR 12
`define POS_SPACING_LO 16
`define POS_SPACING_HI 22

// ----------------------------------------------------------------
// priority_shadow_select fields
// ----------------------------------------------------------------
`define POS_SV_SHADOW 0
`define POS_LEVEL1_SEL 4
`define SEL_WIDTH 4

// ----------------------------------------------------------------
// irq_service_status fields
// ----------------------------------------------------------------
`define POS_LAST_REQ_LO 0
`define POS_LAST_REQ_HI 7
`define POS_REQ_LEVEL_LO 8
`define POS_REQ_LEVEL_HI 10

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_CONTROL 32'h0000_0000
`define RST_SHADOW 32'h0000_0000
`define RST_RELOAD 32'h0000_0000
`define RST_STATUS 32'h0000_0000
`define RST_REQ_LEVEL 3'h0
`define RST_LAST_REQ 8'h00

`endif

// >>> rtl/ext_edge_detect.v
/*
 one external interrupt edge detector with selectable polarity.
 assumes the input is already synchronous to the clock.
*/
`default_nettype none

module ext_edge_detect
(
   input wire ref_clk_in,
   input wire arst_n_in,
   input wire sig_in,
   input wire rising_in,
   output reg event_out
);

   reg prev_reg;

   // ----------------------------------------------------------------
   // edge detection
   // ----------------------------------------------------------------
   // a polarity change while the line is steady gives no event
   always @(posedge ref_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         prev_reg <= 1'b0;
         event_out <= 1'b0;
      end
      else
      begin
         prev_reg <= sig_in;
         if (rising_in)
            event_out <= sig_in & ~prev_reg;
         else
            event_out <= ~sig_in & prev_reg;
      end
   end

endmodule

`default_nettype wire

// >>> rtl/irq_vector_shadow_config.v
/*
 configuration and status of a vectored interrupt controller: mode,
 proximity trigger, edge polarity, shadow set choice, service status,
 with an apb4 register slave. assumes the core pulses present and
 serviced strobes synchronous to ref_clk_in.
*/
// Overview of operation
// - mode bit set gives multi-vector mode, clear gives single-vector
// - trigger level n of 2..7: priority n or lower starts timer
// - trigger level 1: only priority 1 starts the timer
// - trigger level 0: timer disabled, nothing starts it
// - five external inputs, each polarity bit: 1 rising, 0 falling
// - per level 1..7 four-bit field picks shadow set 0 or 1
// - single-vector mode: shadow bit set presents single vector with shadow
// - per-level shadow fields ignored while in single-vector mode
// - read-only field holds priority of latest interrupt presented
// - read-only field holds number of last request serviced
// - unimplemented bits of all registers read as zero
// - one-hot spacing field gives 8..512 bytes, ignored single-vector
// - triggered timer loads its count from software reload value
`default_nettype none
`include "irq_cfg_defs.vh"

module irq_vector_shadow_config
(
   input wire ref_clk_in,
   input wire arst_n_in,
   input wire psel_in,
   input wire penable_in,
   input wire pwrite_in,
   input wire [7:0] paddr_in,
   input wire [31:0] pwdata_in,
   input wire [3:0] pstrb_in,
   output reg [31:0] prdata_out,
   output reg pready_out,
   output reg pslverr_out,
   input wire [4:0] ext_irq_in,
   input wire irq_present_in,
   input wire [2:0] irq_present_level_in,
   input wire irq_serviced_in,
   input wire [7:0] irq_serviced_num_in,
   output wire [4:0] ext_irq_event_out,
   output reg multivector_out,
   output reg [9:0] vector_spacing_out,
   output reg shadow_used_out,
   output reg shadow_set_out,
   output reg prox_start_out,
   output reg [31:0] prox_load_value_out
);

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   function [31:0] merge_strb;
      input [31:0] old_val;
      input [31:0] new_val;
      input [3:0] strb;
      integer i;
      begin
         merge_strb = old_val;
         for (i = 0; i < 4; i = i + 1)
         begin
            if (strb[i])
               merge_strb[i*8 +: 8] = new_val[i*8 +: 8];
         end
      end
   endfunction

   function addr_hit;
      input [7:0] addr;
      begin
         addr_hit = (addr == `OFS_IRQ_CONTROL) ||
                    (addr == `OFS_SHADOW_SELECT) ||
                    (addr == `OFS_SERVICE_STATUS) ||
                    (addr == `OFS_PROX_RELOAD);
      end
   endfunction

   function level_hits;
      input [2:0] trig;
      input [2:0] lvl;
      begin
         if (trig == 3'h0)
            level_hits = 1'b0;
         else if (trig == 3'h1)
            level_hits = (lvl == 3'h1);
         else
            level_hits = (lvl != 3'h0) && (lvl <= trig);
      end
   endfunction

   function [9:0] spacing_bytes;
      input [6:0] code;
      begin
         case (code)
            7'h01: spacing_bytes = 10'h008;
            7'h02: spacing_bytes = 10'h010;
            7'h04: spacing_bytes = 10'h020;
            7'h08: spacing_bytes = 10'h040;
            7'h10: spacing_bytes = 10'h080;
            7'h20: spacing_bytes = 10'h100;
            7'h40: spacing_bytes = 10'h200;
            default: spacing_bytes = 10'h000;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   reg [31:0] control_reg;
   reg [31:0] shadow_reg;
   reg [31:0] reload_reg;
   reg [2:0] req_level_reg;
   reg [7:0] last_req_reg;

   wire multivector_select;
   wire [2:0] proximity_trigger_level;
   wire [4:0] edge_pol;
   wire [6:0] vector_spacing;
   wire single_vector_shadow_use;

   assign multivector_select = control_reg[`POS_MULTIVECTOR];
   assign proximity_trigger_level =
      control_reg[`POS_TRIGGER_HI:`POS_TRIGGER_LO];
   assign edge_pol = control_reg[`POS_EDGE_POL_HI:`POS_EDGE_POL_LO];
   assign vector_spacing = control_reg[`POS_SPACING_HI:`POS_SPACING_LO];
   assign single_vector_shadow_use = shadow_reg[`POS_SV_SHADOW];

   // ----------------------------------------------------------------
   // writable bit masks
   // ----------------------------------------------------------------
   // masks keep unimplemented bits at zero in storage itself
   wire [31:0] control_mask;
   wire [31:0] shadow_mask;

   assign control_mask = 32'h007F_171F;
   assign shadow_mask = 32'hFFFF_FFF1;

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   wire setup_phase;
   wire access_done;
   wire wr_done;
   wire addr_known;
   reg [31:0] rd_mux;

   assign setup_phase = psel_in & ~penable_in;
   assign access_done = psel_in & penable_in & pready_out;
   assign wr_done = access_done & pwrite_in & ~pslverr_out;
   assign addr_known = addr_hit(paddr_in);

   always @*
   begin
      rd_mux = 32'h0000_0000;
      case (paddr_in)
         `OFS_IRQ_CONTROL: rd_mux = control_reg;
         `OFS_SHADOW_SELECT: rd_mux = shadow_reg;
         `OFS_SERVICE_STATUS:
         begin
            rd_mux[`POS_REQ_LEVEL_HI:`POS_REQ_LEVEL_LO] =
               req_level_reg;
            rd_mux[`POS_LAST_REQ_HI:`POS_LAST_REQ_LO] =
               last_req_reg;
         end
         `OFS_PROX_RELOAD: rd_mux = reload_reg;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // ----------------------------------------------------------------
   // apb answer
   // ----------------------------------------------------------------
   // one wait-free access cycle: ready rises with penable
   always @(posedge ref_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out <= 32'h0000_0000;
      end
      else
      begin
         pready_out <= setup_phase;
         if (setup_phase)
         begin
            pslverr_out <= ~addr_known;
            if (!pwrite_in && addr_known)
               prdata_out <= rd_mux;
            else
               prdata_out <= 32'h0000_0000;
         end
         else if (access_done)
         begin
            pslverr_out <= 1'b0;
            prdata_out <= 32'h0000_0000;
         end
      end
   end

   // ----------------------------------------------------------------
   // software registers
   // ----------------------------------------------------------------
   always @(posedge ref_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         control_reg <= `RST_CONTROL;
         shadow_reg <= `RST_SHADOW;
         reload_reg <= `RST_RELOAD;
      end
      else if (wr_done)
      begin
         case (paddr_in)
            `OFS_IRQ_CONTROL:
               control_reg <= merge_strb(control_reg, pwdata_in,
                  pstrb_in) & control_mask;
            `OFS_SHADOW_SELECT:
               shadow_reg <= merge_strb(shadow_reg, pwdata_in,
                  pstrb_in) & shadow_mask;
            `OFS_PROX_RELOAD:
               reload_reg <= merge_strb(reload_reg, pwdata_in,
                  pstrb_in);
            `OFS_SERVICE_STATUS:
               reload_reg <= reload_reg;
            default:
               reload_reg <= reload_reg;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // hardware status
   // ----------------------------------------------------------------
   // only core strobes reach these; the bus path never does
   always @(posedge ref_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         req_level_reg <= `RST_REQ_LEVEL;
         last_req_reg <= `RST_LAST_REQ;
      end
      else
      begin
         if (irq_present_in)
            req_level_reg <= irq_present_level_in;
         if (irq_serviced_in)
            last_req_reg <= irq_serviced_num_in;
      end
   end

   // ----------------------------------------------------------------
   // external edge detectors
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 5; g = g + 1)
      begin : edge_gen
         ext_edge_detect edge_u
         (
            .ref_clk_in(ref_clk_in),
            .arst_n_in(arst_n_in),
            .sig_in(ext_irq_in[g]),
            .rising_in(edge_pol[g]),
            .event_out(ext_irq_event_out[g])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // shadow set choice
   // ----------------------------------------------------------------
   // reserved codes fall back to set 0; software must not write them
   reg [3:0] level_sel;
   reg shadow_next;
   reg used_next;

   always @*
   begin
      level_sel = 4'h0;
      if (irq_present_level_in != 3'h0)
         level_sel = shadow_reg[(irq_present_level_in * `SEL_WIDTH)
            +: `SEL_WIDTH];
      if (multivector_select)
      begin
         shadow_next = (level_sel == 4'h1);
         used_next = 1'b1;
      end
      else
      begin
         shadow_next = single_vector_shadow_use;
         used_next = single_vector_shadow_use;
      end
   end

   // ----------------------------------------------------------------
   // proximity trigger
   // ----------------------------------------------------------------
   // one decode feeds both the start pulse and the reload capture
   wire prox_hit;

   assign prox_hit = irq_present_in &
      level_hits(proximity_trigger_level,
         irq_present_level_in);

   // ----------------------------------------------------------------
   // core facing outputs
   // ----------------------------------------------------------------
   always @(posedge ref_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         multivector_out <= 1'b0;
         vector_spacing_out <= 10'h000;
         shadow_used_out <= 1'b0;
         shadow_set_out <= 1'b0;
         prox_start_out <= 1'b0;
         prox_load_value_out <= 32'h0000_0000;
      end
      else
      begin
         multivector_out <= multivector_select;
         if (multivector_select)
            vector_spacing_out <= spacing_bytes(vector_spacing);
         else
            vector_spacing_out <= 10'h000;
         if (irq_present_in)
         begin
            shadow_used_out <= used_next;
            shadow_set_out <= shadow_next;
         end
         prox_start_out <= prox_hit;
         if (prox_hit)
            prox_load_value_out <= reload_reg;
      end
   end

endmodule

`default_nettype wire

// >>> verif/irq_vector_shadow_config_monitor.sv
/* port assertions for the interrupt config block.
 assumes a bind onto the design top and a single clock domain. */
`default_nettype none
// ----------------------------------------------------------------
// checker
// ----------------------------------------------------------------
module irq_cfg_monitor
(
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   input wire logic [4:0] ext_irq_in,
   input wire logic irq_present_in,
   input wire logic [2:0] irq_present_level_in,
   input wire logic [4:0] ext_irq_event_out,
   input wire logic multivector_out,
   input wire logic shadow_used_out,
   input wire logic prox_start_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk_in);
   endclocking
   default disable iff (!arst_n_in);
   sequence setup_s;
      psel_in && !penable_in;
   endsequence
   sequence access_s;
      pready_out ##1 !pready_out;
   endsequence
   sequence rd_s;
      pready_out && !pwrite_in;
   endsequence
   ready_once_a: assert property (setup_s |=> access_s)
      else $error("ready not one cycle after setup");
   map_err_a: assert property (pready_out |-> pslverr_out ==
      !(paddr_in inside {8'h00, 8'h10, 8'h20, 8'h30}))
      else $error("error flag wrong for address");
   idle_zero_a: assert property (!pready_out |->
      prdata_out == 32'h0000_0000 && !pslverr_out)
      else $error("bus outputs not quiet");
   ctl_zero_a: assert property (rd_s ##0 paddr_in == 8'h00 |->
      (prdata_out & 32'hff80_e8e0) == 32'h0000_0000)
      else $error("control spare bits set");
   shd_zero_a: assert property (rd_s ##0 paddr_in == 8'h10 |->
      (prdata_out & 32'h0000_000e) == 32'h0000_0000)
      else $error("shadow spare bits set");
   sts_zero_a: assert property (rd_s ##0 paddr_in == 8'h20 |->
      (prdata_out & 32'hffff_f800) == 32'h0000_0000)
      else $error("status spare bits set");
   prox_cause_a: assert property (prox_start_out |->
      $past(irq_present_in) && $past(irq_present_level_in) != 3'h0)
      else $error("timer start without cause");
   mv_shadow_a: assert property (irq_present_in ##1 multivector_out
      |-> shadow_used_out)
      else $error("multi mode without shadow set");
   edge_cause_a: assert property (ext_irq_event_out != 5'h00 |->
      (ext_irq_event_out & ~($past(ext_irq_in) ^ $past(ext_irq_in, 2)))
      == 5'h00)
      else $error("event without input change");
endmodule

bind irq_vector_shadow_config irq_cfg_monitor u_mon
(
   .ref_clk_in, .arst_n_in, .psel_in, .penable_in, .pwrite_in,
   .paddr_in, .prdata_out, .pready_out, .pslverr_out, .ext_irq_in,
   .irq_present_in, .irq_present_level_in, .ext_irq_event_out,
   .multivector_out, .shadow_used_out, .prox_start_out
);
`default_nettype wire

// >>> verif/core_model.sv
/* behavioural core: presents interrupts and reports service.
 assumes one bench process calls its tasks. */
`default_nettype none
// ----------------------------------------------------------------
// core strobes
// ----------------------------------------------------------------
module core_model
(
   input wire logic clk_in,
   output logic present_out,
   output logic [2:0] level_out,
   output logic serviced_out,
   output logic [7:0] num_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      present_out <= 1'b0;
      level_out <= 3'h0;
      serviced_out <= 1'b0;
      num_out <= 8'h00;
   end
   // qualifiers go stale after the strobe, so no reuse of old values
   task automatic present(input logic [2:0] lv);
      @(posedge clk_in);
      present_out <= 1'b1;
      level_out <= lv;
      @(posedge clk_in);
      present_out <= 1'b0;
      level_out <= ~lv;
   endtask
   task automatic service(input logic [7:0] n);
      @(posedge clk_in);
      serviced_out <= 1'b1;
      num_out <= n;
      @(posedge clk_in);
      serviced_out <= 1'b0;
      num_out <= ~n;
   endtask
endmodule
`default_nettype wire

// >>> verif/irq_vector_shadow_config_test.sv
/* self-checking bench for the interrupt config block.
 assumes the core model and the bound monitor. */
`default_nettype none
module irq_vector_shadow_config_test;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // signals and instances
   // ----------------------------------------------------------------
   logic ref_clk_in = 1'b0;
   logic arst_n_in = 1'b0;
   logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
   logic [7:0] paddr_in = 8'h00;
   logic [31:0] pwdata_in = 32'h0000_0000;
   logic [3:0] pstrb_in = 4'hf;
   logic [4:0] ext_irq_in = 5'h00;
   logic [31:0] prdata_out, prox_load_value_out, r, rv;
   logic pready_out, pslverr_out, multivector_out, prox_start_out;
   logic shadow_used_out, shadow_set_out, irq_present_in;
   logic irq_serviced_in;
   logic [2:0] irq_present_level_in;
   logic [7:0] irq_serviced_num_in, num;
   logic [9:0] vector_spacing_out;
   logic [4:0] ext_irq_event_out, nx, e5;
   logic [33:0] e;
   logic [33:0] rd_q[$];
   logic [31:0] ld_q[$];
   logic [4:0] ev_q[$];
   int fail_count = 0, cmp_count = 0;
   always #20 ref_clk_in = ~ref_clk_in;
   irq_vector_shadow_config dut
   (
      .ref_clk_in, .arst_n_in, .psel_in, .penable_in, .pwrite_in,
      .paddr_in, .pwdata_in, .pstrb_in, .prdata_out, .pready_out,
      .pslverr_out, .ext_irq_in, .irq_present_in, .irq_present_level_in,
      .irq_serviced_in, .irq_serviced_num_in, .ext_irq_event_out,
      .multivector_out, .vector_spacing_out, .shadow_used_out,
      .shadow_set_out, .prox_start_out, .prox_load_value_out
   );
   core_model core
   (
      .clk_in(ref_clk_in), .present_out(irq_present_in),
      .level_out(irq_present_level_in), .serviced_out(irq_serviced_in),
      .num_out(irq_serviced_num_in)
   );
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      cmp_count++;
      if (g !== x)
      begin
         fail_count++;
         $display("[FAIL] %0t got %h exp %h", $time, g, x);
      end
   endtask
   task automatic close_out;
      if (rd_q.size() + ld_q.size() + ev_q.size() != 0)
      begin
         fail_count++;
         $display("[FAIL] %0t got %h exp %h", $time,
            rd_q.size() + ld_q.size() + ev_q.size(), 0);
      end
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // waits on pready rather than assuming the one-cycle answer
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic er);
      @(posedge ref_clk_in);
      psel_in <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      rd_q.push_back({w, er, d});
      @(posedge ref_clk_in);
      penable_in <= 1'b1;
      do
         @(posedge ref_clk_in);
      while (pready_out !== 1'b1);
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask
   // ----------------------------------------------------------------
   // result watcher and watchdog
   // ----------------------------------------------------------------
   always @(posedge ref_clk_in)
   begin
      if (pready_out === 1'b1)
      begin
         e = rd_q.pop_front();
         chk(32'(pslverr_out), 32'(e[32]));
         if (!e[33])
            chk(prdata_out, e[31:0]);
      end
      if (prox_start_out === 1'b1)
         chk(prox_load_value_out, ld_q.pop_front());
      if (ext_irq_event_out !== 5'h00)
         chk(32'(ext_irq_event_out), 32'(ev_q.pop_front()));
   end
   initial
   begin
      #400000;
      fail_count++;
      close_out();
   end
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial
   begin
      r = $urandom(91);
      repeat (20) @(posedge ref_clk_in);
      arst_n_in <= 1'b1;
      for (int i = 0; i < 4; i++)
         apb(1'b0, 8'(i * 16), 32'h0000_0000, 1'b0);
      apb(1'b1, 8'h04, r, 1'b1);
      apb(1'b0, 8'h04, 32'h0000_0000, 1'b1);
      apb(1'b1, 8'h20, r, 1'b0);
      apb(1'b0, 8'h20, 32'h0000_0000, 1'b0);
      apb(1'b1, 8'h10, r, 1'b0);
      apb(1'b0, 8'h10, r & 32'hffff_fff1, 1'b0);
      apb(1'b1, 8'h00, r, 1'b0);
      apb(1'b0, 8'h00, r & 32'h007f_171f, 1'b0);
      rv = $urandom();
      apb(1'b1, 8'h30, rv, 1'b0);
      apb(1'b0, 8'h30, rv, 1'b0);
      rv[7:0] = ~rv[7:0];
      pstrb_in <= 4'h1;
      apb(1'b1, 8'h30, {~rv[31:8], rv[7:0]}, 1'b0);
      pstrb_in <= 4'hf;
      apb(1'b0, 8'h30, rv, 1'b0);
      $display("test registers done");
      for (int t = 0; t < 8; t++)
      begin
         apb(1'b1, 8'h00, 32'(t) << 8, 1'b0);
         for (int l = 0; l < 8; l++)
         begin
            if (l != 0 && l <= t)
               ld_q.push_back(rv);
            core.present(3'(l));
         end
         apb(1'b0, 8'h20, 32'h0000_0700, 1'b0);
      end
      num = 8'($urandom());
      core.service(num);
      apb(1'b0, 8'h20, {21'h0, 3'h7, num}, 1'b0);
      $display("test proximity and status done");
      r = 32'h0000_1000;
      for (int l = 1; l < 8; l++)
         r[4 * l] = r[4 * l] | 1'($urandom());
      apb(1'b1, 8'h10, r, 1'b0);
      apb(1'b1, 8'h00, 32'h0000_1000, 1'b0);
      for (int l = 1; l < 8; l++)
      begin
         core.present(3'(l));
         @(posedge ref_clk_in);
         chk(32'(multivector_out), 32'h0000_0001);
         chk(32'(shadow_set_out), 32'(r[4 * l]));
      end
      apb(1'b1, 8'h00, 32'h0000_0000, 1'b0);
      for (int b = 0; b < 2; b++)
      begin
         apb(1'b1, 8'h10, r | 32'(b), 1'b0);
         core.present(3'h3);
         @(posedge ref_clk_in);
         chk(32'(multivector_out), 32'h0000_0000);
         chk(32'(shadow_used_out), 32'(b));
         chk(32'(shadow_set_out), 32'(b));
      end
      $display("test shadow done");
      for (int i = 0; i < 9; i++)
      begin
         r = (i < 8) ? 32'h0000_1000 : 32'h0000_0000;
         apb(1'b1, 8'h00, r | (32'h0001_0000 << (i % 8)), 1'b0);
         repeat (2) @(posedge ref_clk_in);
         chk(32'(vector_spacing_out), (i < 7) ? 32'h0000_0008 << i
            : 32'h0000_0000);
      end
      $display("test spacing done");
      for (int k = 0; k < 48; k++)
      begin
         if (k % 8 == 0)
            apb(1'b1, 8'h00, $urandom() & 32'h0000_001f, 1'b0);
         @(posedge ref_clk_in);
         r = 32'(pwdata_in);
         nx = 5'($urandom());
         e5 = (r[4:0] & nx & ~ext_irq_in) | (~r[4:0] & ~nx & ext_irq_in);
         if (e5 != 5'h00)
            ev_q.push_back(e5);
         ext_irq_in <= nx;
      end
      repeat (4) @(posedge ref_clk_in);
      $display("test edges done");
      close_out();
   end
endmodule
`default_nettype wire
